// ==== verilog/plm_pkg.sv ====
// constants for the output macrocell array
package plm_pkg;
   // ==========================================
   // array geometry
   localparam int NCELL      = 10;
   localparam int NIN        = 12;
   localparam int NSIG       = NIN + NCELL;
   localparam int NCOL       = 2 * NSIG;
   localparam int NPT        = 132;
   localparam int PT_CLR     = 0;
   localparam int PT_OE_BASE = 121;
   localparam int PT_SET     = 131;
   localparam int PT_CNT  [NCELL] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
   localparam int PT_BASE [NCELL] = '{1, 9, 19, 31, 45, 61, 77, 91, 103, 113};
   localparam int CLK_PIN    = 0;
   // ==========================================
   // register port
   localparam int AW         = 9;
   localparam int DW         = 32;
   localparam int ROW_LO_W   = 32;
   localparam int ROW_HI_W   = NCOL - ROW_LO_W;
   localparam logic [AW-1:0] FUSE_TOP     = 9'h108;
   localparam logic [AW-1:0] ADDR_MODE    = 9'h110;
   localparam logic [AW-1:0] ADDR_POL     = 9'h111;
   localparam logic [AW-1:0] ADDR_OE      = 9'h112;
   localparam logic [AW-1:0] ADDR_PRELOAD = 9'h113;
   localparam logic [AW-1:0] ADDR_STATUS  = 9'h114;
   // ==========================================
   // field codes and reset values
   localparam logic       MODE_COMB   = 1'b1;
   localparam logic [1:0] OE_SEL_TERM = 2'h0;
   localparam logic [1:0] OE_SEL_ON   = 2'h1;
   localparam logic [1:0] OE_SEL_OFF  = 2'h2;
   localparam logic [NCELL-1:0]   MODE_RST   = 10'h000;
   localparam logic [NCELL-1:0]   POL_RST    = 10'h000;
   localparam logic [2*NCELL-1:0] OE_RST     = 20'h00000;
   localparam logic [NCELL-1:0]   IO_OUT_RST = 10'h3FF;
   localparam logic [NCELL-1:0]   OE_N_RST   = 10'h3FF;
   localparam logic [NCOL-1:0]    FUSE_RST   = 44'h00000000000;
   localparam logic               CELL_RST   = 1'b0;
endpackage

// ==== verilog/plm_cell_ff.sv ====
// one macrocell d flip-flop with clear, preset and preload
`timescale 1ns/1ps
module plm_cell_ff (
   input  wire logic clk,      // system clock
   input  wire logic rst,      // async reset
   input  wire logic d,        // sum term
   input  wire logic cap,      // device clock rising edge seen
   input  wire logic clr,      // shared clear term
   input  wire logic set,      // shared preset term
   input  wire logic load,     // preload strobe
   input  wire logic load_val, // preload value
   output logic      q_next,   // value after this edge
   output logic      q         // stored value
);
   typedef struct packed {
      logic q;
   } plm_cell_st_t;

   plm_cell_st_t st;
   plm_cell_st_t next_st;

   always_comb begin
      next_st = st;
      if (clr) begin
         next_st.q = 1'b0;
      end else if (load) begin
         next_st.q = load_val;
      end else if (cap && set) begin
         next_st.q = 1'b1;
      end else if (cap) begin
         next_st.q = d;
      end
   end

   assign q_next = next_st.q;
   assign q      = st.q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st.q <= plm_pkg::CELL_RST;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // checks
   property p_cell_hold;
      @(posedge clk) disable iff (rst) !cap && !clr && !load |=> $stable(q);
   endproperty
   a_cell_hold: assert property (p_cell_hold) else $error("cell changed without a cause");

   property p_cell_cap;
      @(posedge clk) disable iff (rst) cap && !set && !clr && !load |=> q == $past(d);
   endproperty
   a_cell_cap: assert property (p_cell_cap) else $error("cell missed its sum term");
endmodule

// ==== verilog/plm_fuse_mem.sv ====
// product-term fuse rows with registered readback
`timescale 1ns/1ps
module plm_fuse_mem (
   input  wire logic                        clk,     // system clock
   input  wire logic                        rst,     // async reset
   input  wire logic                        wr,      // write strobe
   input  wire logic                        rd,      // read strobe
   input  wire logic [plm_pkg::AW-1:0]      addr,    // word address
   input  wire logic [plm_pkg::DW-1:0]      wdata,   // write data
   input  wire logic [plm_pkg::DW-1:0]      other,   // read data of non-fuse words
   input  wire logic [plm_pkg::NCOL-1:0]    cols,    // array columns
   output logic      [plm_pkg::NPT-1:0]     pt,      // product terms
   output logic      [plm_pkg::DW-1:0]      rd_data  // read data, registered
);
   typedef struct packed {
      logic [plm_pkg::NPT-1:0][plm_pkg::NCOL-1:0] fuse;
      logic [plm_pkg::DW-1:0]                     rdata;
   } plm_mem_st_t;

   plm_mem_st_t st;
   plm_mem_st_t next_st;
   logic [7:0]  row;
   logic        hit;

   assign row = addr[8:1];
   assign hit = addr < plm_pkg::FUSE_TOP;

   // a cleared bit connects its column; an all-clear row is false
   genvar r;
   generate
      for (r = 0; r < plm_pkg::NPT; r++) begin : g_pt
         assign pt[r] = &(cols | st.fuse[r]);
      end
   endgenerate

   always_comb begin
      next_st       = st;
      next_st.rdata = '0;
      if (wr && hit) begin
         if (addr[0]) begin
            next_st.fuse[row][plm_pkg::NCOL-1:plm_pkg::ROW_LO_W] = wdata[plm_pkg::ROW_HI_W-1:0];
         end else begin
            next_st.fuse[row][plm_pkg::ROW_LO_W-1:0] = wdata;
         end
      end
      if (rd) begin
         if (!hit) begin
            next_st.rdata = other;
         end else if (addr[0]) begin
            next_st.rdata = {20'h00000, st.fuse[row][plm_pkg::NCOL-1:plm_pkg::ROW_LO_W]};
         end else begin
            next_st.rdata = st.fuse[row][plm_pkg::ROW_LO_W-1:0];
         end
      end
   end

   assign rd_data = st.rdata;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st.fuse  <= {plm_pkg::NPT{plm_pkg::FUSE_RST}};
         st.rdata <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule

// ==== verilog/plm_array.sv ====
// ten-cell output macrocell array with its product-term plane
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module plm_array (
   input  wire logic                     clk,       // system clock
   input  wire logic                     rst,       // async reset, active high
   input  wire logic [plm_pkg::AW-1:0]   reg_addr,  // register word address
   input  wire logic [plm_pkg::DW-1:0]   reg_wdata, // register write data
   input  wire logic                     reg_wr,    // write strobe
   input  wire logic                     reg_rd,    // read strobe
   output logic      [plm_pkg::DW-1:0]   reg_rdata, // read data, cycle after strobe
   input  wire logic [plm_pkg::NIN-1:0]  in_pin,    // dedicated inputs, bit 0 is device clock
   input  wire logic [plm_pkg::NCELL-1:0] io_in,    // resolved level of each cell pin
   output logic      [plm_pkg::NCELL-1:0] io_out,   // pin drive value
   output logic      [plm_pkg::NCELL-1:0] io_oe_n   // pin drive enable, low drives
);
   typedef struct packed {
      logic [plm_pkg::NCELL-1:0]      cfg_mode;
      logic [plm_pkg::NCELL-1:0]      cfg_pol;
      logic [plm_pkg::NCELL-1:0][1:0] cfg_oe;
      logic                           clk_q;
      logic [plm_pkg::NCELL-1:0]      io_out;
      logic [plm_pkg::NCELL-1:0]      io_oe_n;
   } plm_st_t;

   plm_st_t                     st;
   plm_st_t                     next_st;
   logic [plm_pkg::NSIG-1:0]    sig;
   logic [plm_pkg::NCOL-1:0]    cols;
   logic [plm_pkg::NPT-1:0]     pt;
   logic [plm_pkg::NCELL-1:0]   fb;
   logic [plm_pkg::NCELL-1:0]   sum;
   logic [plm_pkg::NCELL-1:0]   en;
   logic [plm_pkg::NCELL-1:0]   q;
   logic [plm_pkg::NCELL-1:0]   q_next;
   logic [plm_pkg::NCELL-1:0]   val;
   logic [plm_pkg::DW-1:0]      other;
   logic                        cap;
   logic                        clr_term;
   logic                        set_term;
   logic                        load;

   // ==========================================
   // array inputs and shared terms
   assign cap      = in_pin[plm_pkg::CLK_PIN] & ~st.clk_q;
   assign clr_term = pt[plm_pkg::PT_CLR];
   assign set_term = pt[plm_pkg::PT_SET];
   assign load     = reg_wr && (reg_addr == plm_pkg::ADDR_PRELOAD);
   assign sig      = {fb, in_pin};

   genvar k;
   generate
      for (k = 0; k < plm_pkg::NSIG; k++) begin : g_col
         assign cols[2*k]   = sig[k];
         assign cols[2*k+1] = ~sig[k];
      end
   endgenerate

   plm_fuse_mem u_fuse (
      .clk     (clk),
      .rst     (rst),
      .wr      (reg_wr),
      .rd      (reg_rd),
      .addr    (reg_addr),
      .wdata   (reg_wdata),
      .other   (other),
      .cols    (cols),
      .pt      (pt),
      .rd_data (reg_rdata)
   );

   // ==========================================
   // macrocells
   genvar c;
   generate
      for (c = 0; c < plm_pkg::NCELL; c++) begin : g_cell
         localparam int B = plm_pkg::PT_BASE[c];
         localparam int N = plm_pkg::PT_CNT[c];
         localparam int E = plm_pkg::PT_OE_BASE + c;

         assign sum[c] = |pt[B +: N];

         // registered cells feed back inverted q, combinational cells their pin
         assign fb[c] = (st.cfg_mode[c] == plm_pkg::MODE_COMB) ? io_in[c] : ~q[c];

         always_comb begin
            if (st.cfg_mode[c] != plm_pkg::MODE_COMB) begin
               en[c] = pt[E];
            end else begin
               case (st.cfg_oe[c])
                  plm_pkg::OE_SEL_ON:   en[c] = 1'b1;
                  plm_pkg::OE_SEL_OFF:  en[c] = 1'b0;
                  plm_pkg::OE_SEL_TERM: en[c] = pt[E];
                  default:              en[c] = 1'b0;
               endcase
            end
         end

         plm_cell_ff u_ff (
            .clk      (clk),
            .rst      (rst),
            .d        (sum[c]),
            .cap      (cap),
            .clr      (clr_term),
            .set      (set_term),
            .load     (load),
            .load_val (reg_wdata[c]),
            .q_next   (q_next[c]),
            .q        (q[c])
         );
      end
   endgenerate

   // ==========================================
   // read mux for configuration and status words
   always_comb begin
      case (reg_addr)
         plm_pkg::ADDR_MODE:    other = {22'h000000, st.cfg_mode};
         plm_pkg::ADDR_POL:     other = {22'h000000, st.cfg_pol};
         plm_pkg::ADDR_OE:      other = {12'h000, st.cfg_oe};
         plm_pkg::ADDR_PRELOAD: other = {22'h000000, q};
         plm_pkg::ADDR_STATUS:  other = {10'h000, set_term, clr_term, io_in, sum};
         default:               other = '0;
      endcase
   end

   // ==========================================
   // configuration writes and pin stage
   // polarity sits after the flop, so clear and preset ignore it
   assign val = (st.cfg_mode & sum) | (~st.cfg_mode & q_next);

   always_comb begin
      next_st       = st;
      next_st.clk_q = in_pin[plm_pkg::CLK_PIN];
      if (reg_wr) begin
         case (reg_addr)
            plm_pkg::ADDR_MODE: next_st.cfg_mode = reg_wdata[plm_pkg::NCELL-1:0];
            plm_pkg::ADDR_POL:  next_st.cfg_pol  = reg_wdata[plm_pkg::NCELL-1:0];
            plm_pkg::ADDR_OE:   next_st.cfg_oe   = reg_wdata[2*plm_pkg::NCELL-1:0];
            default:            next_st.cfg_mode = st.cfg_mode;
         endcase
      end
      next_st.io_out  = val ^ ~st.cfg_pol;
      next_st.io_oe_n = ~en;
   end

   assign io_out  = st.io_out;
   assign io_oe_n = st.io_oe_n;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st.cfg_mode <= plm_pkg::MODE_RST;
         st.cfg_pol  <= plm_pkg::POL_RST;
         st.cfg_oe   <= plm_pkg::OE_RST;
         st.clk_q    <= 1'b0;
         st.io_out   <= plm_pkg::IO_OUT_RST;
         st.io_oe_n  <= plm_pkg::OE_N_RST;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_clear;
      clr_term;
   endsequence

   sequence s_preset_edge;
      cap && set_term && !clr_term && !load;
   endsequence

   sequence s_preload;
      load && !clr_term;
   endsequence

   property p_clear;
      s_clear |=> q == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear term left a register set");

   property p_preset;
      s_preset_edge |=> q == '1;
   endproperty
   a_preset: assert property (p_preset) else $error("preset did not load ones");

   property p_clear_wins;
      clr_term && set_term && cap |=> q == '0 ##1 (!cap && !clr_term && !load) [*1] |-> q == '0;
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("preset beat clear");

   property p_preload;
      s_preload |=> q == $past(reg_wdata[plm_pkg::NCELL-1:0]);
   endproperty
   a_preload: assert property (p_preload) else $error("preload value not taken");

   property p_reg_pin;
      ((io_out ^ q ^ ~$past(st.cfg_pol)) & ~$past(st.cfg_mode)) == '0;
   endproperty
   a_reg_pin: assert property (p_reg_pin) else $error("registered pin differs from flop");

   property p_comb_pin;
      ((io_out ^ $past(sum) ^ ~$past(st.cfg_pol)) & $past(st.cfg_mode)) == '0;
   endproperty
   a_comb_pin: assert property (p_comb_pin) else $error("combinational pin differs from sum");

   property p_reg_oe;
      (io_oe_n[0] == ~$past(pt[plm_pkg::PT_OE_BASE])) || $past(st.cfg_mode[0]);
   endproperty
   a_reg_oe: assert property (p_reg_oe) else $error("registered enable not from its term");

   property p_comb_on;
      st.cfg_mode[0] && st.cfg_oe[0] == plm_pkg::OE_SEL_ON |=> !io_oe_n[0];
   endproperty
   a_comb_on: assert property (p_comb_on) else $error("dedicated output not driven");

   property p_comb_off;
      st.cfg_mode[0] && st.cfg_oe[0] == plm_pkg::OE_SEL_OFF |=> io_oe_n[0];
   endproperty
   a_comb_off: assert property (p_comb_off) else $error("dedicated input driven");

   property p_feedback;
      fb == ((st.cfg_mode & io_in) | (~st.cfg_mode & ~q));
   endproperty
   a_feedback: assert property (p_feedback) else $error("feedback source wrong");

   property p_no_edge;
      !cap && !clr_term && !load |=> $stable(q);
   endproperty
   a_no_edge: assert property (p_no_edge) else $error("register moved without device clock edge");

   property p_read_cfg;
      reg_rd && reg_addr == plm_pkg::ADDR_MODE |=> reg_rdata == {22'h000000, $past(st.cfg_mode)};
   endproperty
   a_read_cfg: assert property (p_read_cfg) else $error("mode word read back wrong");
endmodule

// ==== verif/plm_board.sv ====
// board model resolving each cell pin from all drivers
`timescale 1ns/1ps
module plm_board (
   input  wire logic [9:0] io_out,  // device drive value
   input  wire logic [9:0] io_oe_n, // device enable, low drives
   input  wire logic [9:0] ext_en,  // board drives the pin
   input  wire logic [9:0] ext_val, // board drive value
   output logic      [9:0] io_in    // resolved pin level
);
   // ==========================================
   // pin resolution, released pins pulled high
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         if (!io_oe_n[i])
            io_in[i] = io_out[i];
         else if (ext_en[i])
            io_in[i] = ext_val[i];
         else
            io_in[i] = 1'b1;
      end
   end
endmodule

// ==== verif/plm_array_tb_top.sv ====
// self-checking bench for the output macrocell array
`timescale 1ns/1ps
module plm_array_tb_top;
   // ==========================================
   // signals
   logic        clk;
   logic        rst;
   logic [8:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [11:0] in_pin;
   logic [9:0]  io_in;
   logic [9:0]  io_out;
   logic [9:0]  io_oe_n;
   logic [9:0]  ext_en;
   logic [9:0]  ext_val;
   int          failures;
   int          samples_checked;
   int          cycles;
   typedef struct {
      int          a;
      logic [31:0] d;
      logic [31:0] e;
   } plm_row_t;
   plm_row_t rows [5];

   plm_array u_plm_array (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_pin(in_pin),
      .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
   plm_board u_plm_board (.io_out(io_out), .io_oe_n(io_oe_n), .ext_en(ext_en),
      .ext_val(ext_val), .io_in(io_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ==========================================
   // tasks
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic wr(input int a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a[8:0];
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input int a, input logic [31:0] e);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a[8:0];
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask

   // product term r made true by array column c alone
   task automatic row(input int r, input int c);
      logic [43:0] f;
      f = ~(44'h00000000001 << c);
      wr(2 * r, f[31:0]);
      wr(2 * r + 1, {20'h00000, f[43:32]});
   endtask

   task automatic pin(input logic [11:0] v);
      @(posedge clk);
      in_pin <= v;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // ==========================================
   // timeout
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end

   // ==========================================
   // main sequence
   initial begin
      rst = 1'b1; reg_addr = 9'h000; reg_wdata = 32'h00000000; reg_wr = 1'b0; reg_rd = 1'b0;
      in_pin = 12'h000; ext_en = 10'h000; ext_val = 10'h000;
      failures = 0; samples_checked = 0; cycles = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(io_out, 10'h3FF);
      chk(io_oe_n, 10'h3FF);
      rd(9'h113, 32'h00000000);
      rows = '{'{9'h110, 32'hFFFFFFFF, 32'h000003FF}, '{9'h111, 32'hFFFFFFFF, 32'h000003FF},
               '{9'h112, 32'hFFFFFFFF, 32'h000FFFFF}, '{9'h10A, 32'hFFFFFFFF, 32'h00000000},
               '{9'h113, 32'h00000155, 32'h00000155}};
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      // cells 0,3,4 combinational; 1 registered with enable term
      wr(9'h110, 32'h00000019);
      wr(9'h111, 32'h0000001B);
      wr(9'h112, 32'h00000141);
      row(plm_pkg::PT_BASE[0], 2);
      row(plm_pkg::PT_BASE[1], 4);
      row(plm_pkg::PT_OE_BASE + 1, 6);
      row(plm_pkg::PT_BASE[3], 24);
      row(plm_pkg::PT_BASE[4], 26);
      row(plm_pkg::PT_BASE[4] + plm_pkg::PT_CNT[4] - 1, 14);
      row(plm_pkg::PT_CLR, 8);
      row(plm_pkg::PT_SET, 10);
      pin(12'h002);
      chk(io_out[0], 1'b1);
      chk(io_oe_n[0], 1'b0);
      chk(io_out[3], 1'b1);
      pin(12'h000);
      chk(io_out[0], 1'b0);
      wr(9'h111, 32'h0000001A);
      pin(12'h000);
      chk(io_out[0], 1'b1);
      wr(9'h111, 32'h0000001B);
      pin(12'h004);
      chk(io_out[1], 1'b0);
      pin(12'h005);
      chk(io_out[1], 1'b1);
      chk(io_out[4], 1'b0);
      chk(io_oe_n[1], 1'b1);
      pin(12'h00D);
      chk(io_oe_n[1], 1'b0);
      ext_en <= 10'h002;
      ext_val <= 10'h000;
      pin(12'h015);
      rd(9'h113, 32'h00000000);
      chk(io_out[1], 1'b0);
      chk(io_out[4], 1'b1);
      wr(9'h111, 32'h00000019);
      pin(12'h014);
      chk(io_out[1], 1'b1);
      pin(12'h034);
      pin(12'h035);
      rd(9'h113, 32'h00000000);
      pin(12'h020);
      rd(9'h113, 32'h00000000);
      pin(12'h021);
      rd(9'h113, 32'h000003FF);
      pin(12'h080);
      chk(io_out[4], 1'b1);
      wr(9'h112, 32'h00000142);
      ext_en <= 10'h001;
      ext_val <= 10'h001;
      pin(12'h000);
      chk(io_oe_n[0], 1'b1);
      chk(io_out[3], 1'b1);
      ext_val <= 10'h000;
      pin(12'h000);
      chk(io_out[3], 1'b0);
      // cell 0 combinational with its enable from the term, true on input 3
      wr(9'h112, 32'h00000140);
      row(plm_pkg::PT_OE_BASE, 6);
      pin(12'h008);
      chk(io_oe_n[0], 1'b0);
      pin(12'h000);
      chk(io_oe_n[0], 1'b1);
      print_verdict();
   end
endmodule
